// file: rtl/dprc_consts.vh
`ifndef DPRC_CONSTS_VH
`define DPRC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------------------------------
`define DPRC_ADDR_W 4
`define DPRC_REG_RESET_SRC 4'h0
`define DPRC_REG_NV_WRITE 4'h1
`define DPRC_REG_MOTOR_CAP 4'h2
`define DPRC_REG_MOTOR_POLE 4'h3
`define DPRC_REG_CTRL_METHOD 4'h4
`define DPRC_REG_COMM_ERR 4'h5
`define DPRC_REG_STATUS 4'h6
`define DPRC_REG_WRITE_ERR 4'h7

// ----------------------------------------------------------------
// parameter values
// ----------------------------------------------------------------
`define DPRC_SENTINEL 16'h270F
`define DPRC_CAP_MIN 16'h0001
`define DPRC_CAP_MAX 16'h0096
`define DPRC_POLE_2 16'h0002
`define DPRC_POLE_4 16'h0004
`define DPRC_POLE_6 16'h0006
`define DPRC_POLE_8 16'h0008
`define DPRC_POLE_10 16'h000A
`define DPRC_METHOD_ADV 16'h0014
`define DPRC_METHOD_GP 16'h001E
`define DPRC_SEL_ZERO 16'h0000
`define DPRC_SEL_ONE 16'h0001
`define DPRC_ZERO16 16'h0000

// ----------------------------------------------------------------
// control method codes
// ----------------------------------------------------------------
`define DPRC_CM_VF 2'h0
`define DPRC_CM_ADV 2'h1
`define DPRC_CM_GP 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPRC_CLK_HZ 50000000
`define DPRC_BLIND_MS 1000
`define DPRC_BLIND_W 26

`endif

// file: rtl/dprc_nv_store.v
`timescale 1ns/100ps
// ----------------------------------------------------------------
// small parameter store standing in for nonvolatile memory
// ----------------------------------------------------------------
module dprc_nv_store #(
  parameter AW = 3,
  parameter DW = 16
) (
  input wire core_clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // contents survive the logic reset, like a real store
  always @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule // dprc_nv_store

// file: rtl/dprc_reset_ctrl.v
`timescale 1ns/100ps
`include "dprc_consts.vh"
// What this block does
// - reset source 0: network fault reset accepted in any operation mode
// - reset source 1: network fault reset accepted only in network mode
// - network full drive reset honoured in network mode, refused in panel mode
// - fault resets act only while a protective trip is active
// - panel fault reset accepted in both operation modes
// - during a communication line error all network resets are refused
// - link stays up; control commands ignored about 1s after drive reset release
// - storage select 0: fieldbus writes go to nonvolatile store and RAM
// - storage select 1: RAM only; power cycle restores stored values
// - motor capacity 0.1 to 15kW or 9999 (initial, selects V/F)
// - pole count 2,4,6,8,10 or 9999 (initial, selects V/F)
// - valid motor data: method 20 advanced flux, 30 general flux
// - either motor parameter at 9999 forces V/F control
// - switchover input replaces flux vector method with V/F
// - method change while running waits until the drive stops
// - switchover to V/F while running enables only the second-function set
// - line error adds one to error counter; writing 0 clears it
module dprc_reset_ctrl #(
  parameter CLK_HZ = `DPRC_CLK_HZ,
  parameter BLIND_MS = `DPRC_BLIND_MS,
  parameter BLIND_CYCLES = (CLK_HZ / 1000) * BLIND_MS
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [`DPRC_ADDR_W-1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire fb_param_wr_i,
  input wire [`DPRC_ADDR_W-1:0] fb_param_addr_i,
  input wire [15:0] fb_param_wdata_i,
  input wire power_up_i,
  input wire network_mode_i,
  input wire trip_active_i,
  input wire net_fault_reset_request_i,
  input wire net_drive_reset_i,
  input wire panel_fault_reset_i,
  input wire comm_line_error_i,
  input wire vf_switchover_input_i,
  input wire motor_running_i,
  input wire [15:0] control_cmd_i,
  input wire control_cmd_valid_i,
  output reg fault_reset_o,
  output reg drive_reset_o,
  output reg [15:0] control_cmd_o,
  output reg control_cmd_valid_o,
  output wire cmd_blind_o,
  output reg [1:0] control_method_o,
  output reg second_function_o,
  output reg nv_write_o,
  output reg param_reject_o
);

  // ----------------------------------------------------------------
  // range checks
  // ----------------------------------------------------------------
  function is_sel;
    input [15:0] v;
    begin
      is_sel = (v == `DPRC_SEL_ZERO) || (v == `DPRC_SEL_ONE);
    end
  endfunction

  // only the even pole counts of the supported range, or the sentinel
  function pole_ok;
    input [15:0] v;
    begin
      case (v)
        `DPRC_POLE_2: pole_ok = 1'b1;
        `DPRC_POLE_4: pole_ok = 1'b1;
        `DPRC_POLE_6: pole_ok = 1'b1;
        `DPRC_POLE_8: pole_ok = 1'b1;
        `DPRC_POLE_10: pole_ok = 1'b1;
        `DPRC_SENTINEL: pole_ok = 1'b1;
        default: pole_ok = 1'b0;
      endcase
    end
  endfunction

  function param_ok;
    input [`DPRC_ADDR_W-1:0] a;
    input [15:0] v;
    begin
      case (a)
        `DPRC_REG_RESET_SRC: param_ok = is_sel(v);
        `DPRC_REG_NV_WRITE: param_ok = is_sel(v);
        // capacity in 0.1kW units
        `DPRC_REG_MOTOR_CAP: param_ok = (v == `DPRC_SENTINEL) ||
          ((v >= `DPRC_CAP_MIN) && (v <= `DPRC_CAP_MAX));
        `DPRC_REG_MOTOR_POLE: param_ok = pole_ok(v);
        `DPRC_REG_CTRL_METHOD: param_ok = (v == `DPRC_METHOD_ADV) ||
          (v == `DPRC_METHOD_GP);
        `DPRC_REG_COMM_ERR: param_ok = (v == `DPRC_ZERO16);
        default: param_ok = 1'b0;
      endcase
    end
  endfunction

  function is_stored;
    input [`DPRC_ADDR_W-1:0] a;
    begin
      is_stored = (a <= `DPRC_REG_CTRL_METHOD);
    end
  endfunction

  // ----------------------------------------------------------------
  // parameter state
  // ----------------------------------------------------------------
  reg [15:0] reset_src_q;
  reg [15:0] nv_sel_q;
  reg [15:0] motor_cap_q;
  reg [15:0] motor_pole_q;
  reg [15:0] method_sel_q;
  reg [15:0] comm_err_cnt_q;
  reg [15:0] write_err_cnt_q;
  reg line_err_d1_q;
  reg [`DPRC_BLIND_W-1:0] blind_cnt_q;
  reg drive_reset_d1_q;

  // software write has priority over a fieldbus write in the same cycle
  wire sw_wr = reg_wr_i;
  wire fb_wr = fb_param_wr_i && !reg_wr_i;
  wire any_wr = sw_wr || fb_wr;
  wire [`DPRC_ADDR_W-1:0] wr_addr = sw_wr ? reg_addr_i : fb_param_addr_i;
  wire [15:0] wr_data = sw_wr ? reg_wdata_i : fb_param_wdata_i;
  wire wr_ok = any_wr && param_ok(wr_addr, wr_data);

  // ----------------------------------------------------------------
  // nonvolatile store and restore sequence
  // ----------------------------------------------------------------
  wire nv_we;
  wire [15:0] nv_rdata;
  reg [2:0] restore_idx_q;
  reg restore_q;
  reg restore_valid_q;
  reg [2:0] restore_wr_idx_q;

  // fieldbus writes reach the store only with select 0; panel writes always
  assign nv_we = wr_ok && is_stored(wr_addr) &&
    (sw_wr || (nv_sel_q == `DPRC_SEL_ZERO));

  dprc_nv_store #(
    .AW(3),
    .DW(16)
  ) u_store (
    .core_clk_i(core_clk_i),
    .we_i(nv_we),
    .waddr_i(wr_addr[2:0]),
    .wdata_i(wr_data),
    .raddr_i(restore_idx_q),
    .rdata_o(nv_rdata)
  );

  // ----------------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reset_src_q <= `DPRC_SEL_ZERO;
      nv_sel_q <= `DPRC_SEL_ZERO;
      motor_cap_q <= `DPRC_SENTINEL;
      motor_pole_q <= `DPRC_SENTINEL;
      method_sel_q <= `DPRC_METHOD_ADV;
      comm_err_cnt_q <= `DPRC_ZERO16;
      write_err_cnt_q <= `DPRC_ZERO16;
      line_err_d1_q <= 1'b0;
      restore_q <= 1'b0;
      restore_valid_q <= 1'b0;
      restore_idx_q <= 3'h0;
      restore_wr_idx_q <= 3'h0;
      param_reject_o <= 1'b0;
      nv_write_o <= 1'b0;
    end else begin
      line_err_d1_q <= comm_line_error_i;
      nv_write_o <= nv_we;
      param_reject_o <= any_wr && !wr_ok;
      // counts rejected writes only; software reads it at index 7
      if (any_wr && !wr_ok) begin
        write_err_cnt_q <= write_err_cnt_q + 16'h0001;
      end
      // power-up walk over stored words, one cycle of read latency
      if (power_up_i && !restore_q) begin
        restore_q <= 1'b1;
        restore_idx_q <= 3'h0;
        restore_valid_q <= 1'b0;
      end else if (restore_q) begin
        restore_valid_q <= 1'b1;
        restore_wr_idx_q <= restore_idx_q;
        if (restore_idx_q == `DPRC_REG_CTRL_METHOD) begin
          restore_q <= 1'b0;
        end else begin
          restore_idx_q <= restore_idx_q + 3'h1;
        end
      end else begin
        restore_valid_q <= 1'b0;
      end
      // a write arriving during the walk is lost; the restored word wins
      if (restore_valid_q) begin
        case (restore_wr_idx_q)
          3'h0: reset_src_q <= nv_rdata;
          3'h1: nv_sel_q <= nv_rdata;
          3'h2: motor_cap_q <= nv_rdata;
          3'h3: motor_pole_q <= nv_rdata;
          3'h4: method_sel_q <= nv_rdata;
          default: ;
        endcase
      end else if (wr_ok) begin
        case (wr_addr)
          `DPRC_REG_RESET_SRC: reset_src_q <= wr_data;
          `DPRC_REG_NV_WRITE: nv_sel_q <= wr_data;
          `DPRC_REG_MOTOR_CAP: motor_cap_q <= wr_data;
          `DPRC_REG_MOTOR_POLE: motor_pole_q <= wr_data;
          `DPRC_REG_CTRL_METHOD: method_sel_q <= wr_data;
          default: ;
        endcase
      end
      // error increment wins over the clearing write
      if (comm_line_error_i && !line_err_d1_q) begin
        comm_err_cnt_q <= comm_err_cnt_q + 16'h0001;
      end else if (wr_ok && (wr_addr == `DPRC_REG_COMM_ERR)) begin
        comm_err_cnt_q <= `DPRC_ZERO16;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset acceptance
  // ----------------------------------------------------------------
  // line errors shut out every network source; the panel stays usable
  wire net_src_ok = (reset_src_q == `DPRC_SEL_ZERO) ||
    network_mode_i;
  wire net_fault_ok = net_fault_reset_request_i && net_src_ok &&
    trip_active_i && !comm_line_error_i;
  wire panel_fault_ok = panel_fault_reset_i && trip_active_i;
  wire net_drive_ok = net_drive_reset_i && network_mode_i &&
    !comm_line_error_i;

  // each output follows its accepted request one cycle later
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fault_reset_o <= 1'b0;
      drive_reset_o <= 1'b0;
      drive_reset_d1_q <= 1'b0;
    end else begin
      fault_reset_o <= net_fault_ok || panel_fault_ok;
      drive_reset_o <= net_drive_ok;
      drive_reset_d1_q <= drive_reset_o;
    end
  end

  // ----------------------------------------------------------------
  // command blind period after a reset release
  // ----------------------------------------------------------------
  assign cmd_blind_o = (blind_cnt_q != {`DPRC_BLIND_W{1'b0}});

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      blind_cnt_q <= {`DPRC_BLIND_W{1'b0}};
      control_cmd_o <= `DPRC_ZERO16;
      control_cmd_valid_o <= 1'b0;
    end else begin
      // a new drive reset restarts the span; fault resets leave it running
      if (drive_reset_o) begin
        blind_cnt_q <= {`DPRC_BLIND_W{1'b0}};
      end else if (drive_reset_d1_q) begin
        blind_cnt_q <= BLIND_CYCLES[`DPRC_BLIND_W-1:0];
      end else if (cmd_blind_o) begin
        blind_cnt_q <= blind_cnt_q - {{(`DPRC_BLIND_W-1){1'b0}}, 1'b1};
      end
      // link keeps running; only commands are held back
      control_cmd_valid_o <= control_cmd_valid_i && !cmd_blind_o &&
        !drive_reset_o;
      if (control_cmd_valid_i) begin
        control_cmd_o <= control_cmd_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // control method selection
  // ----------------------------------------------------------------
  reg [1:0] method_req;
  always @* begin
    if ((motor_cap_q == `DPRC_SENTINEL) || (motor_pole_q == `DPRC_SENTINEL)) begin
      method_req = `DPRC_CM_VF;
    end else if (vf_switchover_input_i) begin
      method_req = `DPRC_CM_VF;
    end else if (method_sel_q == `DPRC_METHOD_GP) begin
      method_req = `DPRC_CM_GP;
    end else begin
      method_req = `DPRC_CM_ADV;
    end
  end

  // a pending change waits for stop; the running method stays frozen
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      control_method_o <= `DPRC_CM_VF;
      second_function_o <= 1'b0;
    end else begin
      if (!motor_running_i) begin
        control_method_o <= method_req;
        second_function_o <= 1'b0;
      end else if (vf_switchover_input_i &&
                   (control_method_o != `DPRC_CM_VF)) begin
        second_function_o <= 1'b1;
      end else if (!vf_switchover_input_i) begin
        second_function_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // read data stand for one cycle only, then fall back to zero
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `DPRC_ZERO16;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DPRC_REG_RESET_SRC: reg_rdata_o <= reset_src_q;
        `DPRC_REG_NV_WRITE: reg_rdata_o <= nv_sel_q;
        `DPRC_REG_MOTOR_CAP: reg_rdata_o <= motor_cap_q;
        `DPRC_REG_MOTOR_POLE: reg_rdata_o <= motor_pole_q;
        `DPRC_REG_CTRL_METHOD: reg_rdata_o <= method_sel_q;
        `DPRC_REG_COMM_ERR: reg_rdata_o <= comm_err_cnt_q;
        `DPRC_REG_STATUS: reg_rdata_o <= {11'h000, cmd_blind_o,
          second_function_o, control_method_o, comm_line_error_i};
        `DPRC_REG_WRITE_ERR: reg_rdata_o <= write_err_cnt_q;
        default: reg_rdata_o <= `DPRC_ZERO16;
      endcase
    end else begin
      reg_rdata_o <= `DPRC_ZERO16;
    end
  end
endmodule // dprc_reset_ctrl

// file: sim/dprc_checker.sv
`timescale 1ns/100ps
`include "dprc_consts.vh"
// ----------------------------------------------------------------
// port checker for the reset and method logic
// ----------------------------------------------------------------
module dprc_checker #(
  parameter BLIND_CYCLES = 50000000
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire network_mode_i,
  input wire trip_active_i,
  input wire net_fault_reset_request_i,
  input wire net_drive_reset_i,
  input wire panel_fault_reset_i,
  input wire comm_line_error_i,
  input wire vf_switchover_input_i,
  input wire motor_running_i,
  input wire [15:0] control_cmd_i,
  input wire control_cmd_valid_i,
  input wire fault_reset_o,
  input wire drive_reset_o,
  input wire [15:0] control_cmd_o,
  input wire control_cmd_valid_o,
  input wire cmd_blind_o,
  input wire [1:0] control_method_o,
  input wire second_function_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  reg [31:0] blind_len_q;
  wire dr_req = net_drive_reset_i && network_mode_i && !comm_line_error_i;
  wire net_ok = !comm_line_error_i;
  // length of the current blind span in cycles
  always @(posedge core_clk_i) begin
    if (!reset_n_i || !cmd_blind_o) blind_len_q <= 32'h0;
    else blind_len_q <= blind_len_q + 32'h1;
  end
  sequence drive_release;
    drive_reset_o ##1 !drive_reset_o;
  endsequence
  sequence cmd_taken;
    control_cmd_valid_i && !cmd_blind_o && !drive_reset_o;
  endsequence
  a_drive_accept: assert property (dr_req |=> drive_reset_o)
    else $error("network drive reset not honoured");
  a_drive_cause: assert property (drive_reset_o |-> $past(dr_req))
    else $error("drive reset without an allowed request");
  a_fault_cause: assert property (fault_reset_o |-> $past(trip_active_i
    && (panel_fault_reset_i || net_fault_reset_request_i && net_ok)))
    else $error("fault reset without trip or request");
  a_panel_fault: assert property (panel_fault_reset_i && trip_active_i |=> fault_reset_o)
    else $error("panel fault reset refused");
  a_blind_start: assert property (drive_release |-> ##[0:1] cmd_blind_o)
    else $error("blind span did not start");
  a_blind_len: assert property ($fell(cmd_blind_o) |-> blind_len_q == BLIND_CYCLES)
    else $error("blind span has wrong length");
  a_cmd_pass: assert property (cmd_taken |=> control_cmd_valid_o
    && control_cmd_o == $past(control_cmd_i))
    else $error("command not passed on");
  a_run_hold: assert property (motor_running_i |=> $stable(control_method_o))
    else $error("method changed while running");
  a_switch_vf: assert property (vf_switchover_input_i && !motor_running_i
    |=> control_method_o == `DPRC_CM_VF)
    else $error("switchover did not select vf");
  a_second_fn: assert property (motor_running_i && vf_switchover_input_i
    && control_method_o != `DPRC_CM_VF |=> second_function_o)
    else $error("second function not set");
endmodule // dprc_checker

bind dprc_reset_ctrl dprc_checker #(.BLIND_CYCLES(BLIND_CYCLES)) u_chk (.*);

// file: sim/dprc_fb_master.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// fieldbus master model
// ----------------------------------------------------------------
module dprc_fb_master (
  input wire core_clk_i,
  output reg wr_o,
  output reg [3:0] addr_o,
  output reg [15:0] data_o,
  output reg cmd_valid_o,
  output reg switch_o
);
  initial begin
    {wr_o, addr_o, data_o, cmd_valid_o, switch_o} = '0;
  end
  // k=1 command, k=0 parameter write; released address and data lines show the inverse, strobes drop to 0
  task put(input k, input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk_i);
      wr_o <= ~k;
      cmd_valid_o <= k;
      addr_o <= a;
      data_o <= d;
      @(posedge core_clk_i);
      wr_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      addr_o <= ~a;
      data_o <= ~d;
    end
  endtask
  // holds commands back for n clock cycles, without watching the blind flag
  task wait_blind(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // switchover rides a virtual input mapped to function code 18
  task set_switch(input v);
    @(posedge core_clk_i) switch_o <= v;
  endtask
endmodule // dprc_fb_master

// file: sim/test_drive_param_reset_ctrl_select.sv
`timescale 1ns/100ps
`include "dprc_consts.vh"
module test_drive_param_reset_ctrl_select;
  localparam BC = 20;
  reg core_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [3:0] reg_addr_i;
  reg [15:0] reg_wdata_i;
  reg reg_wr_i, reg_rd_i, power_up_i, network_mode_i, trip_active_i, motor_running_i;
  reg net_fault_reset_request_i, net_drive_reset_i, panel_fault_reset_i, comm_line_error_i;
  wire [3:0] fb_param_addr_i;
  wire [15:0] fb_param_wdata_i, control_cmd_i, reg_rdata_o, control_cmd_o;
  wire [1:0] control_method_o;
  wire fb_param_wr_i, control_cmd_valid_i, vf_switchover_input_i, fault_reset_o;
  wire drive_reset_o, control_cmd_valid_o, cmd_blind_o, second_function_o;
  wire nv_write_o, param_reject_o;
  integer errors = 0, comparisons = 0;
  reg seen;
  assign control_cmd_i = fb_param_wdata_i;
  dprc_reset_ctrl #(.BLIND_CYCLES(BC)) uut (.*);
  dprc_fb_master m (.core_clk_i(core_clk_i), .wr_o(fb_param_wr_i), .addr_o(fb_param_addr_i),
    .data_o(fb_param_wdata_i), .cmd_valid_o(control_cmd_valid_i),
    .switch_o(vf_switchover_input_i));
  always #10 core_clk_i = ~core_clk_i;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task close_out;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [15:0] e, input [15:0] g, input string n);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task cm(input [1:0] e, input string n);
    check({14'h0, e}, {14'h0, control_method_o}, n);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e, input string n);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(e, reg_rdata_o, n);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge core_clk_i);
      #1;
    end
  endtask
  // k: 0 network fault, 1 panel fault, 2 network drive reset
  task req(input [1:0] k, input e, input string n);
    begin
      @(posedge core_clk_i);
      {net_drive_reset_i, panel_fault_reset_i, net_fault_reset_request_i} <= 3'h1 << k;
      @(posedge core_clk_i);
      {net_drive_reset_i, panel_fault_reset_i, net_fault_reset_request_i} <= 3'h0;
      #1;
      check({15'h0, e}, {15'h0, k[1] ? drive_reset_o : fault_reset_o}, n);
    end
  endtask
  task watch;
    begin
      seen = 1'b0;
      repeat (3) begin
        #1;
        seen = seen | nv_write_o;
        @(posedge core_clk_i);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    begin
      rd(4'h0, 16'h0000, "reset_src");
      rd(4'h1, 16'h0000, "nv_sel");
      rd(4'h2, `DPRC_SENTINEL, "capacity");
      rd(4'h3, `DPRC_SENTINEL, "poles");
      rd(4'h4, `DPRC_METHOD_ADV, "method_sel");
      cm(`DPRC_CM_VF, "method");
    end
  endtask
  task t_method;
    integer i;
    begin
      wr(4'h2, 16'h000F);
      wr(4'h3, 16'h0004);
      settle;
      cm(`DPRC_CM_ADV, "adv");
      wr(4'h4, `DPRC_METHOD_GP);
      settle;
      cm(`DPRC_CM_GP, "gp");
      for (i = 2; i <= 10; i = i + 2) begin
        wr(4'h3, i[15:0]);
        rd(4'h3, i[15:0], "pole_ok");
      end
      wr(4'h3, 16'h0005);
      #1;
      check(16'h0001, {15'h0, param_reject_o}, "reject");
      rd(4'h3, 16'h000A, "pole_bad");
      wr(4'h2, 16'h0097);
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h000F, "cap_bad");
      wr(4'h4, 16'h0019);
      rd(4'h4, `DPRC_METHOD_GP, "meth_bad");
      rd(4'h7, 16'h0004, "write_err");
      wr(4'h2, `DPRC_SENTINEL);
      settle;
      cm(`DPRC_CM_VF, "sentinel");
      wr(4'h2, 16'h0096);
      rd(4'h2, 16'h0096, "cap_max");
    end
  endtask
  task t_run;
    begin
      @(posedge core_clk_i) motor_running_i <= 1'b1;
      wr(4'h4, `DPRC_METHOD_ADV);
      settle;
      cm(`DPRC_CM_GP, "run_hold");
      m.set_switch(1'b1);
      settle;
      check(16'h0001, {15'h0, second_function_o}, "second");
      cm(`DPRC_CM_GP, "run_sw");
      @(posedge core_clk_i) motor_running_i <= 1'b0;
      settle;
      cm(`DPRC_CM_VF, "stop_sw");
      m.set_switch(1'b0);
      settle;
      cm(`DPRC_CM_ADV, "stop_adv");
    end
  endtask
  task t_resets;
    integer i;
    begin
      @(posedge core_clk_i) trip_active_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        wr(4'h0, {15'h0, i[1]});
        @(posedge core_clk_i) network_mode_i <= i[0];
        req(2'h0, !i[1] || i[0], "net_fault");
        req(2'h1, 1'b1, "panel_fault");
      end
      @(posedge core_clk_i) trip_active_i <= 1'b0;
      req(2'h1, 1'b0, "no_trip_panel");
      req(2'h0, 1'b0, "no_trip_net");
      @(posedge core_clk_i) begin
        trip_active_i <= 1'b1;
        comm_line_error_i <= 1'b1;
      end
      req(2'h0, 1'b0, "lerr_fault");
      req(2'h2, 1'b0, "lerr_drive");
      @(posedge core_clk_i) comm_line_error_i <= 1'b0;
      rd(4'h5, 16'h0001, "err_count");
      wr(4'h5, 16'h0000);
      rd(4'h5, 16'h0000, "err_clear");
    end
  endtask
  task t_store;
    begin
      m.put(1'b0, 4'h2, 16'h0032);
      watch;
      check(16'h0001, {15'h0, seen}, "nv_write");
      rd(4'h2, 16'h0032, "ram_write");
      wr(4'h1, 16'h0001);
      m.put(1'b0, 4'h2, 16'h0064);
      watch;
      check(16'h0000, {15'h0, seen}, "no_nv");
      rd(4'h2, 16'h0064, "ram_only");
      @(posedge core_clk_i) power_up_i <= 1'b1;
      @(posedge core_clk_i) power_up_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      rd(4'h2, 16'h0032, "restored");
    end
  endtask
  task t_drive;
    begin
      @(posedge core_clk_i) network_mode_i <= 1'b0;
      req(2'h2, 1'b0, "panel_drive");
      @(posedge core_clk_i) network_mode_i <= 1'b1;
      req(2'h2, 1'b1, "net_drive");
      repeat (2) @(posedge core_clk_i);
      m.put(1'b1, 4'h0, 16'h005A);
      #1;
      check(16'h0000, {15'h0, control_cmd_valid_o}, "cmd_blind");
      check(16'h0001, {15'h0, cmd_blind_o}, "blind_on");
      rd(4'h6, 16'h0012, "status");
      m.wait_blind(BC);
      m.put(1'b1, 4'h0, 16'h00A5);
      #1;
      check(16'h00A5, control_cmd_o, "cmd_data");
      check(16'h0001, {15'h0, control_cmd_valid_o}, "cmd_ok");
    end
  endtask
  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, power_up_i, network_mode_i} = '0;
    {trip_active_i, motor_running_i, net_fault_reset_request_i} = '0;
    {net_drive_reset_i, panel_fault_reset_i, comm_line_error_i} = '0;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_defaults;
    t_method;
    t_run;
    t_resets;
    t_store;
    t_drive;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    errors = errors + 1;
    close_out;
  end
endmodule // test_drive_param_reset_ctrl_select
